// File: hw/independent_watchdog.sv
// Independent window watchdog: down-counter, window check, APB registers.
//
// Chosen here: register access over APB and the register offsets.
`include "iwdt_defines.svh"

// ==========================================================================
// Summary of operation
// - Count ticks come from the dedicated clock divided by 1,16,32,64,128,256.
// - A 14-bit down-counter decrements once per prescaled tick.
// - Auto-start mode starts counting right after reset release.
// - Software writes 00h then FFh to refresh; that starts or reloads.
// - System reset stops the counter and restores all registers.
// - Counting stops in low-power state when enabled by the count-stop register or, in auto mode, the option word.
// - Register start mode stops counting after underflow or refresh error.
// - Auto mode reloads after a fault; register mode waits for refresh.
// - Window start and end split the count range into permitted periods.
// - A refresh outside the permitted period is an error, like underflow.
// - Select bit 0 gives interrupt requests, 1 gives the reset output.
// - Software reads the current count through the status register.
// - Separate event outputs mark underflow and refresh error.
// - With count-stop set, low-power entry halts counting; stop output driven.
// - Auto mode takes all settings from the option word at reset.
// - Register mode takes settings from registers, applied at each refresh.
module independent_watchdog #(
  parameter int CNT_W = 14,
  parameter int PRESC_W = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`IWDT_ADDR_W-1:0] paddr,
  input wire logic [`IWDT_DATA_W-1:0] pwdata,
  output logic [`IWDT_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Option word and chip power state.
  input wire logic [`IWDT_OPT_W-1:0] option_select_word0,
  input wire logic low_power_state,
  // Dedicated count clock pin.
  input wire logic dedicated_count_clock,
  // Watchdog requests.
  output logic reset_out,
  output logic nmi_req,
  output logic irq,
  // Event link outputs.
  output logic underflow_event,
  output logic refresh_error_event,
  // Sleep-mode count-stop control.
  output logic sleep_count_stop
);

  import iwdt_pkg::*;

  if (CNT_W < 8 || CNT_W > 30) begin : g_check
    $error("independent_watchdog: CNT_W must lie in 8..30");
  end

  // ========================================================================
  // Decode helpers

  function automatic logic [3:0] div_shift_of(input logic [3:0] code);
    case (code)
      `IWDT_CKS_DIV1: div_shift_of = `IWDT_SH_1;
      `IWDT_CKS_DIV16: div_shift_of = `IWDT_SH_16;
      `IWDT_CKS_DIV32: div_shift_of = `IWDT_SH_32;
      `IWDT_CKS_DIV64: div_shift_of = `IWDT_SH_64;
      `IWDT_CKS_DIV128: div_shift_of = `IWDT_SH_128;
      `IWDT_CKS_DIV256: div_shift_of = `IWDT_SH_256;
      default: div_shift_of = `IWDT_SH_1;
    endcase
  endfunction

  // Timeout select picks the reload value: 2^(CNT_W-3+sel) - 1.
  function automatic logic [CNT_W-1:0] reload_of(input logic [1:0] sel);
    reload_of = CNT_W'((1 << (CNT_W - `IWDT_TIMEOUT_SEL_SPAN + sel)) - 1);
  endfunction

  // Window limit as a number of quarters of the timeout period.
  function automatic logic [CNT_W:0] win_lim(input logic [CNT_W:0] qtr,
                                             input logic [2:0] k);
    win_lim = (CNT_W+1)'(qtr * k);
  endfunction

  // ========================================================================
  // State

  run_state_t state;
  run_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic auto_mode;
  logic [15:0] ctrl;
  logic reg_reset_irq_sel;
  logic reg_sleep_count_stop;
  logic [3:0] act_cks;
  logic [1:0] act_timeout_sel;
  logic [1:0] act_window_end_sel;
  logic [1:0] act_window_start_sel;
  logic act_reset_irq_sel;
  logic act_sleep_count_stop;
  logic uf_flag;
  logic re_flag;
  logic [1:0] irq_mask;

  // ========================================================================
  // APB decode

  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire sel_refresh = paddr == `IWDT_OFF_REFRESH;
  wire sel_ctrl = paddr == `IWDT_OFF_CTRL;
  wire sel_status = paddr == `IWDT_OFF_STATUS;
  wire sel_rstirq = paddr == `IWDT_OFF_RSTIRQ;
  wire sel_cstop = paddr == `IWDT_OFF_CSTOP;
  wire sel_mask = paddr == `IWDT_OFF_MASK;
  wire addr_hit = sel_refresh | sel_ctrl | sel_status | sel_rstirq |
                  sel_cstop | sel_mask;

  wire wr_refresh = wr & sel_refresh;
  wire clr_uf = wr & sel_status & pwdata[`IWDT_ST_UF_BIT];
  wire clr_re = wr & sel_status & pwdata[`IWDT_ST_RE_BIT];

  wire [`IWDT_DATA_W-1:0] rd_status =
    (`IWDT_DATA_W)'(cnt) << `IWDT_ST_CNT_LSB |
    (`IWDT_DATA_W)'(uf_flag) << `IWDT_ST_UF_BIT |
    (`IWDT_DATA_W)'(re_flag) << `IWDT_ST_RE_BIT;
  wire [`IWDT_DATA_W-1:0] rd_mask =
    (`IWDT_DATA_W)'(irq_mask[0]) << `IWDT_ST_UF_BIT |
    (`IWDT_DATA_W)'(irq_mask[1]) << `IWDT_ST_RE_BIT;
  wire [`IWDT_DATA_W-1:0] rd_rstirq =
    (`IWDT_DATA_W)'(reg_reset_irq_sel) << `IWDT_SEL_BIT;
  wire [`IWDT_DATA_W-1:0] rd_cstop =
    (`IWDT_DATA_W)'(reg_sleep_count_stop) << `IWDT_SEL_BIT;

  // The refresh register reads as zero.
  wire [`IWDT_DATA_W-1:0] rd_data =
    sel_ctrl ? (`IWDT_DATA_W)'(ctrl) :
    sel_status ? rd_status :
    sel_rstirq ? rd_rstirq :
    sel_cstop ? rd_cstop :
    sel_mask ? rd_mask : '0;

  // ========================================================================
  // Refresh sequence, option fields and window

  logic refresh;

  refresh_seq u_refresh_seq (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .wr_stb(wr_refresh),
    .wr_byte(pwdata[7:0]),
    .refresh(refresh)
  );

  wire opt_auto = option_select_word0[`IWDT_OPT_AUTO];
  wire [3:0] opt_cks = option_select_word0[`IWDT_CKS_MSB:`IWDT_CKS_LSB];
  wire [1:0] opt_timeout_sel = option_select_word0[`IWDT_TIMEOUT_SEL_MSB:`IWDT_TIMEOUT_SEL_LSB];
  wire [1:0] opt_window_end_sel = option_select_word0[`IWDT_WINDOW_END_SEL_MSB:`IWDT_WINDOW_END_SEL_LSB];
  wire [1:0] opt_window_start_sel = option_select_word0[`IWDT_WINDOW_START_SEL_MSB:`IWDT_WINDOW_START_SEL_LSB];
  wire opt_reset_irq_sel = option_select_word0[`IWDT_OPT_RESET_IRQ_SEL];
  wire opt_sleep_count_stop = option_select_word0[`IWDT_OPT_SLEEP_COUNT_STOP];

  wire [3:0] cr_cks = ctrl[`IWDT_CKS_MSB:`IWDT_CKS_LSB];
  wire [1:0] cr_timeout_sel = ctrl[`IWDT_TIMEOUT_SEL_MSB:`IWDT_TIMEOUT_SEL_LSB];
  wire [1:0] cr_window_end_sel = ctrl[`IWDT_WINDOW_END_SEL_MSB:`IWDT_WINDOW_END_SEL_LSB];
  wire [1:0] cr_window_start_sel = ctrl[`IWDT_WINDOW_START_SEL_MSB:`IWDT_WINDOW_START_SEL_LSB];

  wire [CNT_W-1:0] reload = reload_of(act_timeout_sel);
  wire [CNT_W:0] quarter = ({1'b0, reload} + (CNT_W+1)'(1)) >> 2;
  wire [CNT_W:0] start_lim = win_lim(quarter,
                                     {1'b0, act_window_start_sel} + `IWDT_QTR_ONE);
  wire [CNT_W:0] end_lim = win_lim(quarter,
                                   `IWDT_QTR_TOP - {1'b0, act_window_end_sel});
  wire permit = ({1'b0, cnt} < start_lim) & ({1'b0, cnt} >= end_lim);

  // ========================================================================
  // Count ticks and faults

  wire running = state == ST_RUN;
  wire power_stop = low_power_state & act_sleep_count_stop;
  wire cnt_zero = cnt == '0;
  logic tick;

  wire refresh_err = refresh & running & ~permit;
  wire refresh_ok = refresh & ~refresh_err;
  wire underflow = tick & running & cnt_zero;
  wire fault = underflow | refresh_err;
  wire restart = refresh_ok | (fault & auto_mode) | (state == ST_BOOT);

  // In register mode the new control settings apply at the refresh itself.
  wire [1:0] load_timeout_sel = auto_mode ? act_timeout_sel : cr_timeout_sel;
  wire [CNT_W-1:0] load_val = reload_of(load_timeout_sel);

  count_tick_gen #(
    .PRESC_W(PRESC_W)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .dedicated_count_clock(dedicated_count_clock),
    .div_shift(div_shift_of(act_cks)),
    .hold(~running | power_stop),
    .restart(restart),
    .tick(tick)
  );

  // ========================================================================
  // Run state

  always_comb begin
    next_state = state;
    case (state)
      ST_BOOT: begin
        next_state = opt_auto ? ST_RUN : ST_STOP;
      end
      ST_STOP: begin
        if (refresh_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault && !auto_mode) begin
          next_state = ST_STOP;
        end
      end
      default: next_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Down-counter

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (state == ST_BOOT) begin
      cnt <= reload_of(opt_timeout_sel);
    end else if (refresh_ok || (fault && auto_mode)) begin
      cnt <= load_val;
    end else if (underflow) begin
      cnt <= cnt;
    end else if (tick && running) begin
      cnt <= cnt - CNT_W'(1);
    end
  end

  // ========================================================================
  // Active settings

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      auto_mode <= 1'b0;
      act_cks <= 4'(`IWDT_CTRL_RST >> `IWDT_CKS_LSB);
      act_timeout_sel <= 2'(`IWDT_CTRL_RST >> `IWDT_TIMEOUT_SEL_LSB);
      act_window_end_sel <= 2'(`IWDT_CTRL_RST >> `IWDT_WINDOW_END_SEL_LSB);
      act_window_start_sel <= 2'(`IWDT_CTRL_RST >> `IWDT_WINDOW_START_SEL_LSB);
      act_reset_irq_sel <= `IWDT_SEL_RST;
      act_sleep_count_stop <= `IWDT_SEL_RST;
    end else if (state == ST_BOOT) begin
      auto_mode <= opt_auto;
      if (opt_auto) begin
        act_cks <= opt_cks;
        act_timeout_sel <= opt_timeout_sel;
        act_window_end_sel <= opt_window_end_sel;
        act_window_start_sel <= opt_window_start_sel;
        act_reset_irq_sel <= opt_reset_irq_sel;
        act_sleep_count_stop <= opt_sleep_count_stop;
      end
    end else if (refresh_ok && !auto_mode) begin
      act_cks <= cr_cks;
      act_timeout_sel <= cr_timeout_sel;
      act_window_end_sel <= cr_window_end_sel;
      act_window_start_sel <= cr_window_start_sel;
      act_reset_irq_sel <= reg_reset_irq_sel;
      act_sleep_count_stop <= reg_sleep_count_stop;
    end
  end

  // ========================================================================
  // Software registers

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl <= `IWDT_CTRL_RST;
      reg_reset_irq_sel <= `IWDT_SEL_RST;
      reg_sleep_count_stop <= `IWDT_SEL_RST;
      irq_mask <= `IWDT_MASK_RST;
    end else if (wr) begin
      if (sel_ctrl) begin
        ctrl <= pwdata[15:0] & `IWDT_CTRL_MASK;
      end
      if (sel_rstirq) begin
        reg_reset_irq_sel <= pwdata[`IWDT_SEL_BIT];
      end
      if (sel_cstop) begin
        reg_sleep_count_stop <= pwdata[`IWDT_SEL_BIT];
      end
      if (sel_mask) begin
        irq_mask <= {pwdata[`IWDT_ST_RE_BIT], pwdata[`IWDT_ST_UF_BIT]};
      end
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      uf_flag <= 1'b0;
      re_flag <= 1'b0;
    end else begin
      uf_flag <= underflow | (uf_flag & ~clr_uf);
      re_flag <= refresh_err | (re_flag & ~clr_re);
    end
  end

  // ========================================================================
  // APB answer: one wait state, data and error registered

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~addr_hit;
      prdata <= pwrite ? '0 : rd_data;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ========================================================================
  // Request and event outputs

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reset_out <= 1'b0;
      nmi_req <= 1'b0;
      irq <= 1'b0;
      underflow_event <= 1'b0;
      refresh_error_event <= 1'b0;
      sleep_count_stop <= 1'b0;
    end else begin
      reset_out <= fault & act_reset_irq_sel;
      nmi_req <= fault & ~act_reset_irq_sel;
      irq <= |({re_flag, uf_flag} & irq_mask) & ~act_reset_irq_sel;
      underflow_event <= underflow;
      refresh_error_event <= refresh_err;
      sleep_count_stop <= act_sleep_count_stop;
    end
  end

endmodule

// File: hw/iwdt_defines.svh
// Constants for the independent window watchdog: map, fields, resets.
`ifndef IWDT_DEFINES_SVH
`define IWDT_DEFINES_SVH

// ==========================================================================
// Bus widths
`define IWDT_ADDR_W 8
`define IWDT_DATA_W 32
`define IWDT_OPT_W 32

// ==========================================================================
// Register byte offsets
`define IWDT_OFF_REFRESH 8'h00
`define IWDT_OFF_CTRL 8'h04
`define IWDT_OFF_STATUS 8'h08
`define IWDT_OFF_RSTIRQ 8'h0C
`define IWDT_OFF_CSTOP 8'h10
`define IWDT_OFF_MASK 8'h14

// ==========================================================================
// Control register and option word fields (shared layout)
`define IWDT_CKS_MSB 3
`define IWDT_CKS_LSB 0
`define IWDT_TIMEOUT_SEL_MSB 5
`define IWDT_TIMEOUT_SEL_LSB 4
`define IWDT_WINDOW_END_SEL_MSB 9
`define IWDT_WINDOW_END_SEL_LSB 8
`define IWDT_WINDOW_START_SEL_MSB 13
`define IWDT_WINDOW_START_SEL_LSB 12
`define IWDT_OPT_RESET_IRQ_SEL 14
`define IWDT_OPT_SLEEP_COUNT_STOP 15
`define IWDT_OPT_AUTO 16
`define IWDT_CTRL_MASK 16'h333F
`define IWDT_CTRL_RST 16'h3330

// Single-bit select registers and status / mask layout
`define IWDT_SEL_BIT 7
`define IWDT_SEL_RST 1'b0
`define IWDT_ST_CNT_LSB 0
`define IWDT_ST_UF_BIT 14
`define IWDT_ST_RE_BIT 15
`define IWDT_MASK_RST 2'h0

// ==========================================================================
// Refresh sequence bytes
`define IWDT_REFRESH_FIRST 8'h00
`define IWDT_REFRESH_SECOND 8'hFF

// ==========================================================================
// Division select codes and the shifts they give
`define IWDT_CKS_DIV1 4'h0
`define IWDT_CKS_DIV16 4'h4
`define IWDT_CKS_DIV32 4'h5
`define IWDT_CKS_DIV64 4'h6
`define IWDT_CKS_DIV128 4'h7
`define IWDT_CKS_DIV256 4'h8
`define IWDT_SH_1 4'h0
`define IWDT_SH_16 4'h4
`define IWDT_SH_32 4'h5
`define IWDT_SH_64 4'h6
`define IWDT_SH_128 4'h7
`define IWDT_SH_256 4'h8

// ==========================================================================
// Timeout and window arithmetic
`define IWDT_TIMEOUT_SEL_SPAN 3
`define IWDT_QTR_TOP 3'h3
`define IWDT_QTR_ONE 3'h1

`endif

// File: hw/iwdt_pkg.sv
// Types shared by the independent window watchdog modules.
package iwdt_pkg;

  // ========================================================================
  // Counter run state
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_STOP = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

endpackage

// File: hw/count_tick_gen.sv
// Samples the dedicated count clock pin and divides it into count ticks.
`include "iwdt_defines.svh"

module count_tick_gen #(
  parameter int PRESC_W = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Dedicated clock pin.
  input wire logic dedicated_count_clock,
  // Control.
  input wire logic [3:0] div_shift,
  input wire logic hold,
  input wire logic restart,
  // Result.
  output logic tick
);

  if (PRESC_W < 8) begin : g_check
    $error("count_tick_gen: PRESC_W must be at least 8");
  end

  logic sync_a;
  logic sync_b;
  logic prev;
  logic [PRESC_W-1:0] presc;

  // ========================================================================
  // Edge detection and prescaler
  wire pin_rise = sync_b & ~prev;
  wire step = pin_rise & ~hold;
  wire [PRESC_W-1:0] ratio_mask = PRESC_W'((1 << div_shift) - 1);

  assign tick = step & ((presc & ratio_mask) == ratio_mask);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= dedicated_count_clock;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn || restart) begin
      presc <= '0;
    end else if (step) begin
      presc <= presc + PRESC_W'(1);
    end
  end

endmodule

// File: hw/refresh_seq.sv
// Recognises the two-byte refresh sequence written to the refresh register.
`include "iwdt_defines.svh"

module refresh_seq (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Write strobe with byte.
  input wire logic wr_stb,
  input wire logic [7:0] wr_byte,
  // Completed sequence.
  output logic refresh
);

  logic armed;

  wire is_first = wr_byte == `IWDT_REFRESH_FIRST;
  wire is_second = wr_byte == `IWDT_REFRESH_SECOND;

  assign refresh = wr_stb & armed & is_second;

  // Any write other than the first byte drops a pending first step.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      armed <= 1'b0;
    end else if (wr_stb) begin
      armed <= is_first;
    end
  end

endmodule

// File: sim/watchdog_properties.sv
// Concurrent checks on the watchdog's bus answers, requests and events.
`include "iwdt_defines.svh"

module watchdog_properties #(
  parameter int CNT_W = 14,
  parameter int PRESC_W = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic [`IWDT_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Requests and events.
  input wire logic reset_out,
  input wire logic nmi_req,
  input wire logic irq,
  input wire logic underflow_event,
  input wire logic refresh_error_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Sequences
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence

  // ==========================================================================
  // Assertions
  a_apb_answer: assert property (s_setup |=> pready)
    else $error("pready missing after setup and access");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_reset_quiet: assert property (disable iff (1'h0) !rstn |=>
    !(reset_out || nmi_req || irq || pready)) else $error("active in reset");
  a_gate_irq: assert property (reset_out |-> !nmi_req && !irq)
    else $error("interrupt request beside reset output");
  a_uf_request: assert property (underflow_event |-> nmi_req || reset_out)
    else $error("underflow without request");
  a_re_request: assert property (refresh_error_event |-> nmi_req || reset_out)
    else $error("refresh error without request");
  a_event_pulse: assert property ($rose(underflow_event) |=> !underflow_event)
    else $error("underflow event longer than one cycle");
  a_nmi_pulse: assert property (nmi_req |=> !nmi_req [*2])
    else $error("nmi request repeated");
endmodule

bind independent_watchdog watchdog_properties #(
  .CNT_W(CNT_W), .PRESC_W(PRESC_W)
) i_props (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reset_out(reset_out), .nmi_req(nmi_req), .irq(irq),
  .underflow_event(underflow_event),
  .refresh_error_event(refresh_error_event)
);

// File: sim/testbench.sv
// Self-checking bench for the independent window watchdog.
`include "iwdt_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and tables
  logic sys_clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] opt = 32'h0;
  logic lps = 1'h0;
  logic [2:0] dk = 3'h0;
  logic [31:0] prdata, q, v;
  logic pready, pslverr, e, reset_out, nmi_req, irq, uf_ev, re_ev, scs;
  logic [13:0] c0, cnt;
  int fails = 0;
  int cmp_count = 0;
  int n_nmi = 0, n_rst = 0, n_uf = 0, n_re = 0;
  int seed = 32'h5D92;
  localparam logic [7:0] ra [4] = '{8'h04, 8'h0C, 8'h10, 8'h14};
  localparam logic [31:0] rm [4] = '{32'h333F, 32'h80, 32'h80, 32'hC000};
  localparam logic [31:0] rr [4] = '{32'h3330, 32'h0, 32'h0, 32'h0};
  localparam logic [3:0] clock_divide_sel [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  localparam int rat [6] = '{1, 16, 32, 64, 128, 256};
  localparam int pin_per = 8;

  independent_watchdog i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .option_select_word0(opt),
    .low_power_state(lps), .dedicated_count_clock(dk[2]),
    .reset_out(reset_out), .nmi_req(nmi_req), .irq(irq),
    .underflow_event(uf_ev), .refresh_error_event(re_ev),
    .sleep_count_stop(scs)
  );

  // ==========================================================================
  // Clock, count pin and pulse counters
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    dk <= dk + 3'h1;
    n_nmi <= n_nmi + int'(nmi_req === 1'h1);
    n_rst <= n_rst + int'(reset_out === 1'h1);
    n_uf <= n_uf + int'(uf_ev === 1'h1);
    n_re <= n_re + int'(re_ev === 1'h1);
  end

  // ==========================================================================
  // Helpers
  function automatic int reload(input int timeout_sel);
    return (1 << (11 + timeout_sel)) - 1;
  endfunction
  function automatic logic near(input int seen, input int exp);
    return seen >= exp - 1 && seen <= exp + 1;
  endfunction
  task automatic check(input string w, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", w, x, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d = 32'h0);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rf;
    apb(1'h1, 8'h00, 32'h00);
    apb(1'h1, 8'h00, 32'hFF);
  endtask
  task automatic rdc;
    apb(1'h0, 8'h08);
    cnt = q[13:0];
  endtask
  task automatic wait_uf(input int lim);
    int n0;
    n0 = n_uf;
    for (int k = 0; k < lim && n_uf == n0; k++) @(posedge sys_clk);
    cyc(2);
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #1ms;
    fails++;
    close_out;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    cyc(3);
    rstn <= 1'h1;
    cyc(1);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, ra[i]);
      check("reset value", q, rr[i]);
    end
    check("stop output", scs, 1'h0);
    apb(1'h1, 8'h40, 32'hFFFFFFFF);
    check("write refused", e, 1'h1);
    apb(1'h0, 8'h40);
    check("read refused", e, 1'h1);
    check("read as zero", q, 32'h0);
    repeat (3) for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'h1, ra[i], v);
      apb(1'h0, ra[i]);
      check("readback", q, v & rm[i]);
    end
    // A broken sequence must leave the stopped counter alone.
    apb(1'h1, 8'h04, 32'h3300);
    apb(1'h1, 8'h0C, 32'h0);
    apb(1'h1, 8'h10, 32'h0);
    rdc;
    c0 = cnt;
    apb(1'h1, 8'h00, 32'h00);
    apb(1'h1, 8'h00, 32'h55);
    apb(1'h1, 8'h00, 32'hFF);
    cyc(100);
    rdc;
    check("no start", cnt, c0);
    rf;
    cyc(100);
    rdc;
    check("started", cnt < reload(0) && cnt > reload(0) - 20, 1'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, 8'h04, 32'h3300 | clock_divide_sel[i]);
      rf;
      cyc(4 * pin_per * rat[i]);
      rdc;
      check("ticks", near(reload(0) - cnt, 4), 1'h1);
    end
    // Underflow with interrupt requests.
    apb(1'h1, 8'h04, 32'h3300);
    apb(1'h1, 8'h14, 32'h4000);
    rf;
    wait_uf(18000);
    check("uf events", n_uf, 1);
    check("nmi events", n_nmi, 1);
    check("reset events", n_rst, 0);
    check("irq set", irq, 1'h1);
    rdc;
    c0 = cnt;
    check("uf flag", q[15:14], 2'h1);
    cyc(50);
    rdc;
    check("stop after uf", cnt, c0);
    apb(1'h1, 8'h14, 32'h0);
    cyc(2);
    check("irq masked", irq, 1'h0);
    apb(1'h1, 8'h08, 32'h4000);
    // Both sources unmasked, so the later gate check has a set flag to hide.
    apb(1'h1, 8'h14, 32'hC000);
    cyc(2);
    apb(1'h0, 8'h08);
    check("cleared", {irq, q[15:14]}, 3'h0);
    // Narrow window with reset output selected.
    apb(1'h1, 8'h04, 32'h0300);
    apb(1'h1, 8'h0C, 32'h80);
    rf;
    cyc(12500);
    rf;
    rdc;
    check("no early error", n_re, 0);
    check("in window", cnt > reload(0) - 10, 1'h1);
    rf;
    cyc(2);
    check("err event", n_re, 1);
    check("err reset", n_rst, 1);
    check("err no nmi", n_nmi, 1);
    check("irq gated", irq, 1'h0);
    rdc;
    c0 = cnt;
    check("err flag", q[15], 1'h1);
    cyc(50);
    rdc;
    check("stop after err", cnt, c0);
    // Count stop in the low-power state.
    apb(1'h1, 8'h04, 32'h3300);
    apb(1'h1, 8'h0C, 32'h0);
    apb(1'h1, 8'h10, 32'h80);
    rf;
    cyc(2);
    check("stop output", scs, 1'h1);
    lps <= 1'h1;
    rdc;
    c0 = cnt;
    cyc(100);
    rdc;
    check("halted", cnt, c0);
    lps <= 1'h0;
    cyc(100);
    rdc;
    check("resumed", cnt < c0, 1'h1);
    // Auto-start from the option word, reset in mid-run.
    rstn <= 1'h0;
    opt <= 32'h0001B300;
    cyc(3);
    rstn <= 1'h1;
    cyc(2);
    apb(1'h0, 8'h14);
    check("mask reset", q, 32'h0);
    check("opt stop", scs, 1'h1);
    cyc(200);
    rdc;
    check("auto run", cnt < reload(0) && cnt > reload(0) - 40, 1'h1);
    wait_uf(17000);
    check("auto uf", n_uf, 2);
    check("auto nmi", n_nmi, 2);
    cyc(100);
    rdc;
    check("auto reload", cnt > reload(0) - 20, 1'h1);
    close_out;
  end
endmodule
